// ==== rtl/itss_pkg.sv ====
`default_nettype none
// ------------------------------------------------------------
// Register map, fields and timing constants
// ------------------------------------------------------------
package itss_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_IDLE_CTRL = 8'h00;
    localparam logic [7:0] OFS_IRQ_CTRL = 8'h04;
    localparam logic [7:0] OFS_GLOBAL_EN = 8'h08;
    localparam logic [7:0] OFS_FAST_SEL = 8'h0C;
    localparam logic [7:0] OFS_TMR_BASE = 8'h20;
    localparam logic [7:0] TMR_STRIDE = 8'h10;
    localparam logic [7:0] OFS_TMR_CTRL = 8'h00;
    localparam logic [7:0] OFS_TMR_CNT = 8'h04;
    localparam logic [7:0] OFS_TMR_RA = 8'h08;
    localparam logic [7:0] OFS_TMR_RB = 8'h0C;
    localparam int PEND_BIT = 5;
    localparam int WEN_BIT = 4;
    localparam int RESV_BIT = 3;
    localparam int DUAL_CLK_BIT = 5;
    localparam int CORE_CLK_BIT = 4;
    localparam logic [7:0] IDLE_CTRL_RST = 8'hC0;
    localparam logic [3:0] CLK_BITS_ALL_ZERO = 4'h0;
    localparam logic [2:0] SEL_MAX = 3'h4;
    localparam logic [3:0] SEL_SHIFT_TOP = 4'h4;
    localparam int WAKE_BASE_BIT = 11;
    localparam logic [15:0] WAKE_CNT_RST = 16'hFFFF;
    localparam int INSTR_DIV = 10;
    localparam logic [3:0] INSTR_DIV_LAST = 4'(INSTR_DIV - 1);
    localparam logic [2:0] MODE_PWM = 3'h0;
    localparam logic [2:0] MODE_EVENT = 3'h1;
    localparam logic [2:0] MODE_CAPTURE = 3'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ==== rtl/itss_top.sv ====
`default_nettype none
module itss_top #(
    parameter int NUM_TMR = 3
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [itss_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [itss_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic slow_clk_in,
    output logic wake_irq_req,
    output logic idle_exit_clr,
    output logic wake_time_base,
    output logic dev_reset_req,
    input wire logic [NUM_TMR-1:0] timer_io_pin_in,
    output logic [NUM_TMR-1:0] timer_io_pin_out,
    output logic [NUM_TMR-1:0] timer_io_pin_oe,
    input wire logic [NUM_TMR-1:0] timer_input_pin
);
    import itss_pkg::*;

    logic aw_have_reg, w_have_reg;
    logic [ADDR_W-1:0] aw_addr_reg, rd_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic wr_go;
    logic wr_hit;
    logic [31:0] rd_val;
    logic rd_hit;
    logic [7:0] idle_ctrl_reg;
    logic pend_reg, wen_reg, global_en_reg;
    logic [1:0] fast_sel_reg;
    logic [3:0] pre_cnt_reg;
    logic instr_tick;
    logic slow_sel;
    logic [2:0] slow_sync_reg;
    logic slow_lvl_reg;
    logic slow_tick;
    logic wake_tick;
    logic [15:0] wake_cnt_reg;
    logic [2:0] sel_eff;
    logic [15:0] wake_shift;
    logic underflow;
    logic [15:0] tcnt [NUM_TMR];
    logic [15:0] tra [NUM_TMR];
    logic [15:0] trb [NUM_TMR];
    logic [3:0] tctl [NUM_TMR];

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;

    // Write address and data latches, taken in either order
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_have_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end else if (wr_go) begin
                w_have_reg <= 1'b0;
            end
        end
    end

    // Write decode for the fixed and timer registers
    always_comb begin
        wr_hit = aw_addr_reg == OFS_IDLE_CTRL ||
                 aw_addr_reg == OFS_IRQ_CTRL ||
                 aw_addr_reg == OFS_GLOBAL_EN ||
                 aw_addr_reg == OFS_FAST_SEL;
        for (int i = 0; i < NUM_TMR; i++) begin
            if (aw_addr_reg[7:4] == 4'(2 + i) && aw_addr_reg[1:0] == 2'b00) begin
                wr_hit = 1'b1;
            end
        end
    end

    // Write response
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read multiplexer
    always_comb begin
        rd_val = '0;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            OFS_IDLE_CTRL: rd_val = {24'h0000_00, idle_ctrl_reg};
            OFS_IRQ_CTRL: rd_val = {26'h000_0000, pend_reg, wen_reg, 4'h0};
            OFS_GLOBAL_EN: rd_val = {31'h0000_0000, global_en_reg};
            OFS_FAST_SEL: rd_val = {30'h0000_0000, fast_sel_reg};
            default: rd_hit = 1'b0;
        endcase
        for (int i = 0; i < NUM_TMR; i++) begin
            if (s_axi_araddr[7:4] == 4'(2 + i)) begin
                rd_hit = 1'b1;
                case (s_axi_araddr[3:0])
                    OFS_TMR_CTRL[3:0]: rd_val = {28'h000_0000, tctl[i]};
                    OFS_TMR_CNT[3:0]: rd_val = {16'h0000, tcnt[i]};
                    OFS_TMR_RA[3:0]: rd_val = {16'h0000, tra[i]};
                    OFS_TMR_RB[3:0]: rd_val = {16'h0000, trb[i]};
                    default: rd_hit = 1'b0;
                endcase
            end
        end
    end

    // Read data channel, answered one cycle after the address
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
            rd_addr_reg <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rd_addr_reg <= s_axi_araddr;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Period and clock control; all-zero clock bits only request reset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            idle_ctrl_reg <= IDLE_CTRL_RST;
            dev_reset_req <= 1'b0;
        end else begin
            dev_reset_req <= 1'b0;
            if (wr_go && aw_addr_reg == OFS_IDLE_CTRL && w_strb_reg[0]) begin
                if (w_data_reg[7:4] == CLK_BITS_ALL_ZERO) begin
                    dev_reset_req <= 1'b1;
                end else begin
                    idle_ctrl_reg <= {w_data_reg[7:4], 1'b0,
                                      w_data_reg[2:0]};
                end
            end
        end
    end

    // Interrupt control; a new underflow beats a software clear
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pend_reg <= 1'b0;
            wen_reg <= 1'b0;
            global_en_reg <= 1'b0;
            fast_sel_reg <= 2'b00;
        end else begin
            if (underflow) begin
                pend_reg <= 1'b1;
            end else if (wr_go && aw_addr_reg == OFS_IRQ_CTRL &&
                         w_strb_reg[0]) begin
                pend_reg <= w_data_reg[PEND_BIT];
            end
            if (wr_go && aw_addr_reg == OFS_IRQ_CTRL && w_strb_reg[0]) begin
                wen_reg <= w_data_reg[WEN_BIT];
            end
            if (wr_go && aw_addr_reg == OFS_GLOBAL_EN && w_strb_reg[0]) begin
                global_en_reg <= w_data_reg[0];
            end
            if (wr_go && aw_addr_reg == OFS_FAST_SEL && w_strb_reg[0]) begin
                fast_sel_reg <= w_data_reg[1:0];
            end
        end
    end

    // Interrupt request gate
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wake_irq_req <= 1'b0;
        end else begin
            wake_irq_req <= pend_reg && wen_reg && global_en_reg;
        end
    end

    // ------------------------------------------------------------
    // Clock selection and prescaler
    // ------------------------------------------------------------
    assign slow_sel = idle_ctrl_reg[DUAL_CLK_BIT] ||
                      idle_ctrl_reg[CORE_CLK_BIT];

    // Divide-by-10 instruction tick, held still in slow modes
    always_ff @(posedge mclk) begin
        if (!rst_n || slow_sel) begin
            pre_cnt_reg <= 4'h0;
        end else if (pre_cnt_reg == INSTR_DIV_LAST) begin
            pre_cnt_reg <= 4'h0;
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 4'h1;
        end
    end
    assign instr_tick = !slow_sel && pre_cnt_reg == INSTR_DIV_LAST;

    // 32 kHz pin synchroniser; level follows when stages agree
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            slow_sync_reg <= 3'b000;
            slow_lvl_reg <= 1'b0;
        end else begin
            slow_sync_reg <= {slow_sync_reg[1:0], slow_clk_in};
            if (slow_sync_reg[1] == slow_sync_reg[2]) begin
                slow_lvl_reg <= slow_sync_reg[2];
            end
        end
    end
    assign slow_tick = slow_sync_reg[1] && slow_sync_reg[2] && !slow_lvl_reg;
    assign wake_tick = slow_sel ? slow_tick : instr_tick;

    // ------------------------------------------------------------
    // Wake timer
    // ------------------------------------------------------------
    // Undefined codes fall back to the longest period
    assign sel_eff = idle_ctrl_reg[2:0] > SEL_MAX ? SEL_MAX :
                     idle_ctrl_reg[2:0];
    assign wake_shift = wake_cnt_reg << (SEL_SHIFT_TOP - {1'b0, sel_eff});
    assign underflow = wake_tick && wake_shift == 16'h0000;

    // Free-running down counter, invisible to software
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wake_cnt_reg <= WAKE_CNT_RST;
        end else if (wake_tick) begin
            wake_cnt_reg <= wake_cnt_reg - 16'h0001;
        end
    end

    // Idle exit and time base pulses
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            idle_exit_clr <= 1'b0;
            wake_time_base <= 1'b0;
        end else begin
            idle_exit_clr <= underflow;
            wake_time_base <= wake_tick;
        end
    end

    // ------------------------------------------------------------
    // General timers
    // ------------------------------------------------------------
    for (genvar g = 0; g < NUM_TMR; g++) begin : g_tmr
        logic [15:0] cnt_reg, ra_reg, rb_reg;
        logic [3:0] ctl_reg;
        logic [2:0] io_sync_reg, in_sync_reg;
        logic io_lvl_reg, in_lvl_reg, io_prev_reg, in_prev_reg;
        logic next_a_reg, out_reg;
        logic tick, io_edge, in_edge, run, cnt_en;
        logic wr_t;
        logic [7:0] base;

        assign base = OFS_TMR_BASE + 8'(g) * TMR_STRIDE;
        assign wr_t = wr_go && aw_addr_reg[7:4] == base[7:4];
        // Second and third timers may run every mclk
        if (g == 0) begin : g_slow
            assign tick = instr_tick;
        end else begin : g_fast
            assign tick = fast_sel_reg[g-1] ? 1'b1 : instr_tick;
        end
        assign io_edge = io_lvl_reg && !io_prev_reg;
        assign in_edge = in_lvl_reg && !in_prev_reg;
        assign run = ctl_reg[0];
        assign cnt_en = ctl_reg[3:1] == MODE_EVENT ? io_edge && run :
                        ctl_reg[3:1] == MODE_PWM ? tick && run : tick;

        // Pin synchronisers and edge memory
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                io_sync_reg <= 3'b000;
                in_sync_reg <= 3'b000;
                io_lvl_reg <= 1'b0;
                in_lvl_reg <= 1'b0;
                io_prev_reg <= 1'b0;
                in_prev_reg <= 1'b0;
            end else begin
                io_sync_reg <= {io_sync_reg[1:0], timer_io_pin_in[g]};
                in_sync_reg <= {in_sync_reg[1:0], timer_input_pin[g]};
                if (io_sync_reg[1] == io_sync_reg[2]) begin
                    io_lvl_reg <= io_sync_reg[2];
                end
                if (in_sync_reg[1] == in_sync_reg[2]) begin
                    in_lvl_reg <= in_sync_reg[2];
                end
                io_prev_reg <= io_lvl_reg;
                in_prev_reg <= in_lvl_reg;
            end
        end

        // Mode, start and PWM phase control
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                ctl_reg <= 4'h0;
                next_a_reg <= 1'b1;
                out_reg <= 1'b0;
            end else begin
                if (wr_t && aw_addr_reg[3:0] == OFS_TMR_CTRL[3:0] &&
                    w_strb_reg[0]) begin
                    ctl_reg <= w_data_reg[3:0];
                    next_a_reg <= 1'b1;
                end else if (cnt_en && ctl_reg[3:1] == MODE_PWM &&
                             cnt_reg == 16'h0000) begin
                    next_a_reg <= !next_a_reg;
                    out_reg <= !out_reg;
                end
            end
        end

        // Counter and reload/capture words, not reset
        always_ff @(posedge mclk) begin
            if (wr_t && aw_addr_reg[3:0] == OFS_TMR_CNT[3:0]) begin
                if (w_strb_reg[0]) cnt_reg[7:0] <= w_data_reg[7:0];
                if (w_strb_reg[1]) cnt_reg[15:8] <= w_data_reg[15:8];
            end else if (cnt_en) begin
                if (ctl_reg[3:1] == MODE_PWM && cnt_reg == 16'h0000) begin
                    cnt_reg <= next_a_reg ? ra_reg : rb_reg;
                end else begin
                    cnt_reg <= cnt_reg - 16'h0001;
                end
            end
            if (wr_t && aw_addr_reg[3:0] == OFS_TMR_RA[3:0]) begin
                if (w_strb_reg[0]) ra_reg[7:0] <= w_data_reg[7:0];
                if (w_strb_reg[1]) ra_reg[15:8] <= w_data_reg[15:8];
            end else if (ctl_reg[3:1] == MODE_CAPTURE && io_edge) begin
                ra_reg <= cnt_reg;
            end
            if (wr_t && aw_addr_reg[3:0] == OFS_TMR_RB[3:0]) begin
                if (w_strb_reg[0]) rb_reg[7:0] <= w_data_reg[7:0];
                if (w_strb_reg[1]) rb_reg[15:8] <= w_data_reg[15:8];
            end else if (ctl_reg[3:1] == MODE_CAPTURE && in_edge) begin
                rb_reg <= cnt_reg;
            end
        end

        // Pin drive only in PWM mode
        assign timer_io_pin_out[g] = out_reg;
        assign timer_io_pin_oe[g] = ctl_reg[3:1] == MODE_PWM;
        assign tcnt[g] = cnt_reg;
        assign tra[g] = ra_reg;
        assign trb[g] = rb_reg;
        assign tctl[g] = ctl_reg;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic [16:0] since_uf_reg;
    logic sel_chg_reg;
    logic [2:0] sel_prev_reg;

    // Ticks between underflows, voided by a period change
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            since_uf_reg <= '0;
            sel_chg_reg <= 1'b1;
            sel_prev_reg <= 3'h0;
        end else begin
            sel_prev_reg <= sel_eff;
            if (underflow) begin
                since_uf_reg <= '0;
                sel_chg_reg <= sel_prev_reg != sel_eff;
            end else begin
                since_uf_reg <= since_uf_reg + 17'(wake_tick);
                if (sel_prev_reg != sel_eff) sel_chg_reg <= 1'b1;
            end
        end
    end

    sequence s_idle_period_and_clock_ctrl_zero_wr;
        wr_go && aw_addr_reg == OFS_IDLE_CTRL && w_strb_reg[0] &&
        w_data_reg[7:4] == CLK_BITS_ALL_ZERO;
    endsequence
    sequence s_reset_pulse;
        dev_reset_req ##1 !dev_reset_req;
    endsequence

    AST_UF_SETS_PEND: assert property (@(posedge mclk) disable iff (!rst_n)
        underflow |=> pend_reg ##1 (pend_reg || !wr_go))
        else $error("underflow did not set pending flag");
    AST_IDLE_EXIT: assert property (@(posedge mclk) disable iff (!rst_n)
        underflow |=> idle_exit_clr ##1 !idle_exit_clr)
        else $error("idle exit pulse wrong");
    AST_IRQ_GATE: assert property (@(posedge mclk) disable iff (!rst_n)
        !(pend_reg && wen_reg && global_en_reg) |=> !wake_irq_req)
        else $error("interrupt raised without all enables");
    AST_PRESCALE_STOP: assert property (@(posedge mclk) disable iff (!rst_n)
        slow_sel [*2] |-> pre_cnt_reg == 4'h0 && !instr_tick)
        else $error("prescaler ran in slow mode");
    AST_PERIOD: assert property (@(posedge mclk) disable iff (!rst_n)
        underflow && !sel_chg_reg && sel_prev_reg == sel_eff |->
        since_uf_reg == (17'h0_1000 << sel_eff) - 17'h0_0001)
        else $error("wake period wrong");
    AST_RESET_SEL: assert property (@(posedge mclk)
        !rst_n |=> idle_ctrl_reg[2:0] == 3'h0)
        else $error("period select not cleared by reset");
    AST_DEV_RESET: assert property (@(posedge mclk) disable iff (!rst_n)
        s_idle_period_and_clock_ctrl_zero_wr |=> s_reset_pulse)
        else $error("zero clock bits did not request reset");
    AST_FAST_SEL_READ: assert property (@(posedge mclk) disable iff (!rst_n)
        s_axi_rvalid && rd_addr_reg == OFS_FAST_SEL |->
        s_axi_rdata[31:2] == '0)
        else $error("fast select upper bits not zero");
    AST_SLOW_CLK: assert property (@(posedge mclk) disable iff (!rst_n)
        slow_sel && wake_tick |-> $rose(slow_lvl_reg) == 1'b0 && slow_tick)
        else $error("wake tick not from slow clock");
    AST_FAST_TMR: assert property (@(posedge mclk) disable iff (!rst_n)
        fast_sel_reg[0] && !slow_sel && !wr_go [*2] |->
        g_tmr[1].tick)
        else $error("second timer not on mclk");
endmodule
`default_nettype wire

// ==== verification/idle_timer_and_timer_speed_select_test.sv ====
`default_nettype none
// ------------------------------------------------------------
// Self-checking bench for the wake timer and fast select
// ------------------------------------------------------------
module idle_timer_and_timer_speed_select_test;
    timeunit 1ns;
    timeprecision 1ps;
    import itss_pkg::*;
    logic mclk, rst_n, awv, wv, bready, arv, rready, slow_clk_in, slow_run;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic awready, wready, bvalid, arready, rvalid;
    logic irq, exitp, base, devrst;
    logic [1:0] bresp, rresp, div;
    logic [2:0] pout, poe;
    int mismatches, n_compared, cyc, base_cnt, devrst_cnt, seed, b, fsel_m;
    int exitq[$];

    itss_top dut (.mclk(mclk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .slow_clk_in(slow_clk_in), .wake_irq_req(irq),
        .idle_exit_clr(exitp), .wake_time_base(base),
        .dev_reset_req(devrst), .timer_io_pin_in(3'h0),
        .timer_io_pin_out(pout), .timer_io_pin_oe(poe),
        .timer_input_pin(3'h0));

    // Clock at 100 MHz
    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end

    // Pulse monitors and slow clock source
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (base === 1'h1) base_cnt <= base_cnt + 1;
        if (devrst === 1'h1) devrst_cnt <= devrst_cnt + 1;
        if (exitp === 1'h1) exitq.push_back(cyc);
        if (slow_run) begin
            div <= div + 2'h1;
            slow_clk_in <= div[1];
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (mismatches == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Bus master tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awv <= 1'h1;
        wv <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge mclk);
            n++;
            if (awv && awready) awv <= 1'h0;
            if (wv && wready) wv <= 1'h0;
        end while (bvalid !== 1'h1 && n < 100);
        check({30'h0, bresp}, {30'h0, er});
        bready <= 1'h0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        int n = 0;
        araddr <= a;
        arv <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge mclk);
            n++;
            if (arv && arready) arv <= 1'h0;
        end while (rvalid !== 1'h1 && n < 100);
        check(rdata, ed);
        check({30'h0, rresp}, {30'h0, er});
        rready <= 1'h0;
        @(posedge mclk);
    endtask

    task automatic wait_exits(input int k);
        int n = 0;
        while (exitq.size() < k && n < 50000) begin
            @(posedge mclk);
            n++;
        end
    endtask

    // Watchdog against a hang
    initial begin
        #950000;
        mismatches++;
        tally_and_finish;
    end

    // Main sequence
    initial begin
        {awv, wv, bready, arv, rready, slow_clk_in, slow_run} = 7'h0;
        {awaddr, araddr, wdata, wstrb, div} = 54'h0;
        {mismatches, n_compared, cyc, base_cnt, devrst_cnt} = '0;
        seed = 32'h1a3d;
        rst_n = 1'h0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'h1;
        @(posedge mclk);
        check({29'h0, poe}, 32'h0000_0007);
        check({29'h0, pout}, 32'h0000_0000);
        rd(OFS_IDLE_CTRL, 32'h0000_00C0, RESP_OKAY);
        rd(OFS_FAST_SEL, 32'h0000_0000, RESP_OKAY);
        repeat (3) begin
            fsel_m = $random(seed);
            wr(OFS_FAST_SEL, 32'(fsel_m), RESP_OKAY);
            rd(OFS_FAST_SEL, 32'(fsel_m & 3), RESP_OKAY);
        end
        wr(8'h28, 32'h0000_1234, RESP_OKAY);
        rd(8'h28, 32'h0000_1234, RESP_OKAY);
        wr(OFS_IDLE_CTRL, 32'h0000_00C7, RESP_OKAY);
        rd(OFS_IDLE_CTRL, 32'h0000_00C7, RESP_OKAY);
        wr(OFS_IDLE_CTRL, 32'h0000_00C0, RESP_OKAY);
        wr(8'h10, 32'h0000_00FF, RESP_SLVERR);
        rd(8'h10, 32'h0000_0000, RESP_SLVERR);
        wr(OFS_IDLE_CTRL, 32'h0000_0005, RESP_OKAY);
        repeat (3) @(posedge mclk);
        check(32'(devrst_cnt), 32'h0000_0001);
        rd(OFS_IDLE_CTRL, 32'h0000_00C0, RESP_OKAY);
        b = base_cnt;
        repeat (200) @(posedge mclk);
        check(32'(base_cnt - b), 32'h0000_0014);
        wr(OFS_IRQ_CTRL, 32'h0000_0010, RESP_OKAY);
        wr(OFS_GLOBAL_EN, 32'h0000_0001, RESP_OKAY);
        wait_exits(1);
        check(32'(exitq.size()), 32'h0000_0001);
        rd(OFS_IRQ_CTRL, 32'h0000_0030, RESP_OKAY);
        check({31'h0, irq}, 32'h0000_0001);
        wr(OFS_GLOBAL_EN, 32'h0000_0000, RESP_OKAY);
        repeat (3) @(posedge mclk);
        check({31'h0, irq}, 32'h0000_0000);
        wr(OFS_GLOBAL_EN, 32'h0000_0001, RESP_OKAY);
        repeat (3) @(posedge mclk);
        check({31'h0, irq}, 32'h0000_0001);
        wr(OFS_IRQ_CTRL, 32'h0000_0010, RESP_OKAY);
        repeat (3) @(posedge mclk);
        check({31'h0, irq}, 32'h0000_0000);
        // Slow mode, with the slow clock first held still and then running
        wr(OFS_IDLE_CTRL, 32'h0000_00E0, RESP_OKAY);
        b = base_cnt;
        repeat (200) @(posedge mclk);
        check(32'(base_cnt - b), 32'h0000_0000);
        slow_run <= 1'h1;
        wait_exits(3);
        check(32'(exitq.size()), 32'h0000_0003);
        check(32'(exitq[2] - exitq[1]), 32'h0000_4000);
        rd(OFS_IRQ_CTRL, 32'h0000_0030, RESP_OKAY);
        tally_and_finish;
    end
endmodule
`default_nettype wire
